// file: adg_pkg.sv
package adg_pkg;
    // Byte addresses on the register port
    localparam logic [7:0] DAC_CODE_LO_ADDR = 8'h30;
    localparam logic [7:0] DAC_CODE_HI_ADDR = 8'h31;
    localparam logic [7:0] PIN_CTRL_LO_ADDR = 8'h32;
    localparam logic [7:0] PIN_CTRL_HI_ADDR = 8'h33;
    localparam logic [7:0] MISC_LO_ADDR = 8'h34;
    localparam logic [7:0] MISC_HI_ADDR = 8'h35;
    localparam logic [7:0] ADC_RESULT_LO_ADDR = 8'h36;
    localparam logic [7:0] ADC_RESULT_HI_ADDR = 8'h37;
    localparam logic [7:0] COMMAND_LO_ADDR = 8'h3E;
    localparam logic [7:0] COMMAND_HI_ADDR = 8'h3F;

    // Field layout
    localparam int DAC_WIDTH = 12;
    localparam int ADC_WIDTH = 12;
    localparam int PIN_COUNT = 2;
    localparam int CMD_DAC_LATCH_BIT = 2;
    localparam int PIN_DIR_LSB = 0;
    localparam int PIN_LEVEL_LSB = 8;
    localparam int MISC_DR_SEL_BIT = 0;
    localparam int MISC_DR_POL_BIT = 1;
    localparam int MISC_DR_EN_BIT = 2;
    localparam int MISC_SELF_TEST_BIT = 8;

    // Writable bits of each register
    localparam logic [15:0] DAC_CODE_MASK = 16'h0FFF;
    localparam logic [15:0] PIN_CTRL_MASK = 16'h0303;
    localparam logic [15:0] MISC_MASK = 16'h0107;

    // Reset values
    localparam logic [15:0] DAC_CODE_RESET = 16'h0000;
    localparam logic [15:0] PIN_CTRL_RESET = 16'h0000;
    localparam logic [15:0] MISC_RESET = 16'h0000;
    localparam logic [15:0] ADC_RESULT_RESET = 16'h0000;

    typedef struct packed {
        logic claim;
        logic level;
    } adg_pin_drive_type;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } adg_reg_req_type;
endpackage : adg_pkg

// file: adg_pin_arbiter.sv
`timescale 1ns/1ns
`default_nettype none
module adg_pin_arbiter (
    input wire logic clock, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire adg_pkg::adg_pin_drive_type readyDrive, // Data-ready claim
    input wire adg_pkg::adg_pin_drive_type alarmDrive, // Alarm claim
    input wire adg_pkg::adg_pin_drive_type userDrive, // Plain pin setting
    output logic pinOut, // Level driven on the pin
    output logic pinOe // High while the pin is driven
);
    import adg_pkg::*;

    logic pinOut_next;
    logic pinOe_next;

    // Data-ready first, alarm second, plain setting last
    assign pinOe_next = readyDrive.claim | alarmDrive.claim | userDrive.claim;
    assign pinOut_next = readyDrive.claim ? readyDrive.level :
                         alarmDrive.claim ? alarmDrive.level :
                         userDrive.claim & userDrive.level;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pinOut <= 1'b0;
            pinOe <= 1'b0;
        end else begin
            pinOut <= pinOut_next;
            pinOe <= pinOe_next;
        end
    end

    a_ready_wins: assert property (@(posedge clock) disable iff (!rst_n)
        readyDrive.claim |=> pinOe && pinOut == $past(readyDrive.level))
        else $error("data-ready claim did not own the pin");
    a_alarm_over_user: assert property (@(posedge clock) disable iff (!rst_n)
        !readyDrive.claim && alarmDrive.claim |=> pinOe && pinOut == $past(alarmDrive.level))
        else $error("alarm claim did not override plain setting");
    a_user_drive: assert property (@(posedge clock) disable iff (!rst_n)
        !readyDrive.claim && !alarmDrive.claim |=> pinOe == $past(userDrive.claim))
        else $error("plain direction setting not applied");
endmodule : adg_pin_arbiter
`default_nettype wire

// file: adg_aux_control.sv
// Contract
// - Converter result reads as 12-bit unsigned straight binary, zero to reference.
// - Latest 12-bit converter result is readable by software.
// - Writing a DAC code byte only updates the held code, not the output.
// - Writing one to command bit 2 copies held code into the DAC.
// - DAC code uses bits 11:0; bits 15:12 have no function.
// - DAC code maps linearly, zero to 0 V, 0x0FFF to 2.5 V.
// - DAC code register is read/write and clears to zero on reset.
// - Two bidirectional pins, direction and level set by pin control register.
// - Pin control bits 1:0 set direction of pins 1 and 0; one means output.
// - Pin control bits 9:8 set levels of pins 1 and 0; others unused.
// - Pin control register clears to zero on reset, pins become inputs.
// - Pin priority: data-ready first, alarm second, plain pin setting last.
// - Misc bit 2 enables data-ready, bit 1 active high, bit 0 selects pin 1.
`timescale 1ns/1ns
`default_nettype none
module adg_aux_control #(
    parameter int DAC_BITS = 12, // DAC code width
    parameter int ADC_BITS = 12 // Converter result width
) (
    input wire logic clock, // System clock, 25 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire adg_pkg::adg_reg_req_type regReq, // Byte register access
    output logic [7:0] regRdata, // Read byte, one cycle after read
    input wire logic [ADC_BITS-1:0] adcResult, // Finished conversion value
    input wire logic adcValid, // Pulse: adcResult is new
    input wire logic sampleDoneFlag, // Data-ready event, high while ready
    input wire logic [1:0] alarmClaim, // Alarm function owns pin n
    input wire logic [1:0] alarmLevel, // Level alarm wants on pin n
    input wire logic [1:0] auxPinIn, // Pin levels as seen at the pads
    output logic [1:0] auxPinOut, // Pin output levels
    output logic [1:0] auxPinOe, // Pin output enables
    output logic [DAC_BITS-1:0] dacLevel, // Code applied to the DAC
    output logic selfTestEn // Self-test enable
);
    import adg_pkg::*;

    logic [15:0] dacCode_reg;
    logic [15:0] dacCode_next;
    logic [15:0] pinCtrl_reg;
    logic [15:0] pinCtrl_next;
    logic [15:0] miscSetup_reg;
    logic [15:0] miscSetup_next;
    logic [15:0] adcResult_reg;
    logic [DAC_BITS-1:0] dacLevel_reg;
    logic [7:0] regRdata_reg;
    logic [7:0] rdata_next;

    wire wrLo = regReq.write & ~regReq.addr[0];
    wire wrHi = regReq.write & regReq.addr[0];
    wire [7:0] wordAddr = {regReq.addr[7:1], 1'b0};
    wire hitDac = regReq.write && wordAddr == DAC_CODE_LO_ADDR;
    wire hitPin = regReq.write && wordAddr == PIN_CTRL_LO_ADDR;
    wire hitMisc = regReq.write && wordAddr == MISC_LO_ADDR;
    wire latchCmd = wrLo && regReq.addr == COMMAND_LO_ADDR
                    && regReq.wdata[CMD_DAC_LATCH_BIT];

    // Lower address carries the low byte of each word
    function automatic logic [15:0] merge(input logic [15:0] old, input logic lo,
                                          input logic hi, input logic [7:0] b,
                                          input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (lo) begin
            v[7:0] = b;
        end
        if (hi) begin
            v[15:8] = b;
        end
        merge = v & mask;
    endfunction : merge

    assign dacCode_next = hitDac ? merge(dacCode_reg, wrLo, wrHi, regReq.wdata,
                                         DAC_CODE_MASK) : dacCode_reg;
    assign pinCtrl_next = hitPin ? merge(pinCtrl_reg, wrLo, wrHi, regReq.wdata,
                                         PIN_CTRL_MASK) : pinCtrl_reg;
    assign miscSetup_next = hitMisc ? merge(miscSetup_reg, wrLo, wrHi, regReq.wdata,
                                            MISC_MASK) : miscSetup_reg;

    always_comb begin
        case (regReq.addr)
            DAC_CODE_LO_ADDR: rdata_next = dacCode_reg[7:0];
            DAC_CODE_HI_ADDR: rdata_next = dacCode_reg[15:8];
            PIN_CTRL_LO_ADDR: rdata_next = pinCtrl_reg[7:0];
            PIN_CTRL_HI_ADDR: rdata_next = pinCtrl_reg[15:8];
            MISC_LO_ADDR: rdata_next = miscSetup_reg[7:0];
            MISC_HI_ADDR: rdata_next = miscSetup_reg[15:8];
            ADC_RESULT_LO_ADDR: rdata_next = adcResult_reg[7:0];
            ADC_RESULT_HI_ADDR: rdata_next = adcResult_reg[15:8];
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dacCode_reg <= DAC_CODE_RESET;
            pinCtrl_reg <= PIN_CTRL_RESET;
            miscSetup_reg <= MISC_RESET;
        end else begin
            dacCode_reg <= dacCode_next;
            pinCtrl_reg <= pinCtrl_next;
            miscSetup_reg <= miscSetup_next;
        end
    end

    // Output only moves on the latch command
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dacLevel_reg <= '0;
        end else if (latchCmd) begin
            dacLevel_reg <= dacCode_reg[DAC_BITS-1:0];
        end
    end

    // Unsigned straight binary, zero extended
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            adcResult_reg <= ADC_RESULT_RESET;
        end else if (adcValid) begin
            adcResult_reg <= {{(16-ADC_BITS){1'b0}}, adcResult};
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            regRdata_reg <= 8'h00;
        end else if (regReq.read) begin
            regRdata_reg <= rdata_next;
        end
    end

    assign regRdata = regRdata_reg;
    assign dacLevel = dacLevel_reg;
    assign selfTestEn = miscSetup_reg[MISC_SELF_TEST_BIT];

    wire readyEn = miscSetup_reg[MISC_DR_EN_BIT];
    wire readyPol = miscSetup_reg[MISC_DR_POL_BIT];
    wire readySel = miscSetup_reg[MISC_DR_SEL_BIT];

    genvar p;
    generate
        for (p = 0; p < PIN_COUNT; p++) begin : g_pin
            adg_pin_drive_type readyDrive;
            adg_pin_drive_type alarmDrive;
            adg_pin_drive_type userDrive;
            assign readyDrive.claim = readyEn && (readySel == 1'(p));
            assign readyDrive.level = readyPol ? sampleDoneFlag : ~sampleDoneFlag;
            assign alarmDrive.claim = alarmClaim[p];
            assign alarmDrive.level = alarmLevel[p];
            assign userDrive.claim = pinCtrl_reg[PIN_DIR_LSB+p];
            assign userDrive.level = pinCtrl_reg[PIN_LEVEL_LSB+p];
            adg_pin_arbiter u_pin (
                .clock(clock),
                .rst_n(rst_n),
                .readyDrive(readyDrive),
                .alarmDrive(alarmDrive),
                .userDrive(userDrive),
                .pinOut(auxPinOut[p]),
                .pinOe(auxPinOe[p])
            );
        end
    endgenerate

    a_dac_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !latchCmd |=> $stable(dacLevel))
        else $error("DAC output moved without latch command");
    a_dac_latch: assert property (@(posedge clock) disable iff (!rst_n)
        latchCmd |=> dacLevel == $past(dacCode_reg[DAC_BITS-1:0]))
        else $error("latch command did not load held code");
    a_dac_unused: assert property (@(posedge clock) disable iff (!rst_n)
        dacCode_reg[15:12] == 4'h0)
        else $error("unused DAC code bits set");
    a_dac_reset: assert property (@(posedge clock)
        !rst_n |=> dacCode_reg == DAC_CODE_RESET && dacLevel == '0)
        else $error("DAC code not cleared by reset");
    a_pins_reset: assert property (@(posedge clock)
        !rst_n |=> pinCtrl_reg == PIN_CTRL_RESET && auxPinOe == 2'b00)
        else $error("pins not released after reset");
    a_low_byte: assert property (@(posedge clock) disable iff (!rst_n)
        regReq.write && regReq.addr == DAC_CODE_LO_ADDR
        |=> dacCode_reg[7:0] == $past(regReq.wdata) && $stable(dacCode_reg[15:8]))
        else $error("lower address did not load low byte");
    a_adc_capture: assert property (@(posedge clock) disable iff (!rst_n)
        adcValid ##1 regReq.read && regReq.addr == ADC_RESULT_LO_ADDR && !adcValid
        |=> regRdata == $past(adcResult[7:0], 2))
        else $error("converter result not readable");
    a_ready_pin: assert property (@(posedge clock) disable iff (!rst_n)
        readyEn && readySel
        |=> auxPinOe[1] && auxPinOut[1] == ($past(readyPol) ~^ $past(sampleDoneFlag)))
        else $error("data-ready pin not driven");
endmodule : adg_aux_control
`default_nettype wire

// file: adg_board_model.sv
`timescale 1ns/1ns
`default_nettype none
module adg_board_model (
    input wire logic [1:0] auxPinOut, // Device pin levels
    input wire logic [1:0] auxPinOe, // Device drives pin
    input wire logic [1:0] boardOe, // Board drives pin
    input wire logic [1:0] boardLevel, // Level the board drives
    output logic [1:0] auxPinIn // Resolved pad levels
);
    // Device wins, then board, else the pull-up holds the pad high
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            auxPinIn[i] = auxPinOe[i] ? auxPinOut[i] : (boardOe[i] ? boardLevel[i] : 1'b1);
        end
    end
endmodule : adg_board_model
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import adg_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    adg_reg_req_type regReq = '0;
    logic [7:0] regRdata;
    logic [11:0] adcResult = 12'h000;
    logic adcValid = 1'b0;
    logic sampleDoneFlag = 1'b0;
    logic [1:0] alarmClaim = 2'b00;
    logic [1:0] alarmLevel = 2'b00;
    logic [1:0] auxPinIn;
    logic [1:0] auxPinOut;
    logic [1:0] auxPinOe;
    logic [11:0] dacLevel;
    logic selfTestEn;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [15:0] prev = 16'h0000;
    logic [15:0] codes [3] = '{16'hF123, 16'h0FFF, 16'h0000};
    logic [7:0] miscVal [5] = '{8'h04, 8'h07, 8'h06, 8'h05, 8'h03};
    logic flagVal [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [1:0] expOut [5] = '{2'b10, 2'b01, 2'b10, 2'b01, 2'b11};

    always #20 clock = ~clock;

    adg_aux_control adg_aux_control_inst (.clock(clock), .rst_n(rst_n), .regReq(regReq),
        .regRdata(regRdata), .adcResult(adcResult), .adcValid(adcValid),
        .sampleDoneFlag(sampleDoneFlag), .alarmClaim(alarmClaim), .alarmLevel(alarmLevel),
        .auxPinIn(auxPinIn), .auxPinOut(auxPinOut), .auxPinOe(auxPinOe),
        .dacLevel(dacLevel), .selfTestEn(selfTestEn));
    adg_board_model adg_board_model_inst (.auxPinOut(auxPinOut), .auxPinOe(auxPinOe),
        .boardOe(2'b01), .boardLevel(2'b00), .auxPinIn(auxPinIn));

    task give_verdict;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    // Strobe stays up until the next task or idle replaces it
    task wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        regReq = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    endtask : wr

    task idle;
        step(1);
        regReq = '0;
    endtask : idle

    task rd16(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] w;
        for (int b = 0; b < 2; b++) begin
            step(1);
            regReq = '{write: 1'b0, read: 1'b1, addr: a + 8'(b), wdata: 8'h00};
            idle;
            w[8*b +: 8] = regRdata;
        end
        chk(w, exp);
    endtask : rd16

    task pins(input logic [1:0] oe, input logic [1:0] out);
        idle;
        step(2);
        chk({12'h000, auxPinOe, auxPinOut}, {12'h000, oe, out});
    endtask : pins

    initial begin
        #1_000_000;
        n_mismatch++;
        give_verdict;
    end

    initial begin
        step(10);
        rst_n = 1'b1;
        chk({4'h0, dacLevel}, 16'h0000);
        chk({12'h000, auxPinOe, auxPinOut}, 16'h0000);
        rd16(DAC_CODE_LO_ADDR, DAC_CODE_RESET);
        rd16(PIN_CTRL_LO_ADDR, PIN_CTRL_RESET);
        // High byte first, then low byte, then latch
        for (int i = 0; i < 3; i++) begin
            wr(DAC_CODE_HI_ADDR, codes[i][15:8]);
            wr(DAC_CODE_LO_ADDR, codes[i][7:0]);
            idle;
            chk({4'h0, dacLevel}, prev);
            rd16(DAC_CODE_LO_ADDR, codes[i] & DAC_CODE_MASK);
            wr(COMMAND_LO_ADDR, 8'h04);
            idle;
            step(1);
            chk({4'h0, dacLevel}, codes[i] & DAC_CODE_MASK);
            prev = codes[i] & DAC_CODE_MASK;
        end
        rd16(8'h40, 16'h0000);
        adcResult = 12'hABC;
        adcValid = 1'b1;
        step(1);
        adcValid = 1'b0;
        wr(ADC_RESULT_LO_ADDR, 8'h55);
        rd16(ADC_RESULT_LO_ADDR, 16'h0ABC);
        wr(PIN_CTRL_LO_ADDR, 8'hFF);
        wr(PIN_CTRL_HI_ADDR, 8'hFE);
        pins(2'b11, 2'b10);
        rd16(PIN_CTRL_LO_ADDR, 16'h0203);
        alarmClaim = 2'b01;
        alarmLevel = 2'b01;
        pins(2'b11, 2'b11);
        for (int i = 0; i < 5; i++) begin
            sampleDoneFlag = flagVal[i];
            wr(MISC_LO_ADDR, miscVal[i]);
            pins(2'b11, expOut[i]);
        end
        wr(PIN_CTRL_LO_ADDR, 8'h02);
        pins(2'b11, 2'b11);
        wr(MISC_HI_ADDR, 8'h01);
        idle;
        step(1);
        chk({15'h0000, selfTestEn}, 16'h0001);
        rd16(MISC_LO_ADDR, 16'h0103);
        alarmClaim = 2'b00;
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        chk({12'h000, auxPinOe, auxPinOut}, 16'h0000);
        chk({15'h0000, selfTestEn}, 16'h0000);
        rd16(DAC_CODE_LO_ADDR, 16'h0000);
        rd16(PIN_CTRL_LO_ADDR, 16'h0000);
        give_verdict;
    end
endmodule : testbench
`default_nettype wire
